// >>> lmi_fifo.sv
// small fifo between serial receive and the parallel byte stream
`timescale 1ns/1ps
module lmi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } lmi_fifo_st_t;
    lmi_fifo_st_t s_q;
    lmi_fifo_st_t s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic full;
    logic empty;
    assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    assign empty = s_q.wp == s_q.rp;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[s_q.rp[AW-1:0]];
    always_comb begin
        s_d = s_q;
        if (in_valid && !full) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_d.rp = s_q.rp + 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem_q[s_q.wp[AW-1:0]] <= in_data;
        end
    end
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    fifo_no_overflow_a: assert property (@(posedge core_clk) disable iff (!resetn)
        full |-> ##1 (s_q.wp == $past(s_q.wp)) || $past(out_ready))
        else $error("fifo pointer moved while full");
endmodule

// >>> lmi_media_mux.sv
// media pin multiplexer: token-ring or csma/cd mode on one pin set
// How it works
// - csma mode when select2 high, select1 low; ring mode when both high.
// - in csma mode drive pair held true high, complement low.
// - csma transmit data changes in step with the 10 MHz transmit clock.
// - transmit enable high exactly while serial data carries frame bits.
// - csma loopback output high wraps through front end, low normal.
// - ring acquisition high asks frequency centering, low phase lock.
// - ring insert output enables phantom drive for insertion.
// - ring receive data accepted only while ready input low.
// - wire-fault input low means phantom current imbalance.
// - ring wrap output low loops back, high normal.
// - test inputs a and b low float all outputs.
// - external match high copies frame and sets recognized bits.
// - external fail high blocks external match copy and bits.
// - both external match inputs ignored in copy-all-frames mode.
`timescale 1ns/1ps
module lmi_media_mux (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic net_select_0,
    input wire logic net_select_1,
    input wire logic net_select_2,
    input wire logic test_in_a,
    input wire logic test_in_b,
    input wire logic test_in_c,
    input wire logic ring_ref_or_tx_clock,
    input wire logic recovered_or_rx_clock,
    input wire logic rx_serial_in,
    input wire logic ring_ready_or_carrier,
    input wire logic wire_fault_or_collision,
    input wire logic ext_match,
    input wire logic ext_fail_to_match,
    output logic ring_diff_drive,
    output logic ring_diff_drive_n,
    output logic acq_ctl_or_tx_serial,
    output logic insert_or_loopback_ctl,
    output logic wrap_or_tx_enable,
    output logic pins_oe,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic loopback_req,
    input wire logic wide_acq_req,
    input wire logic insert_req,
    input wire logic ring_tx_bit,
    input wire logic copy_all_frames_mode,
    input wire logic internal_match,
    input wire logic frame_end,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_overrun,
    output logic carrier_active,
    output logic collision_seen,
    output logic wire_fault,
    output logic copy_frame,
    output logic recognized_copied_bits,
    output logic [1:0] mode
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] txc_s;
        logic [1:0] rxc_s;
        logic [1:0] rxd_s;
        logic [1:0] crs_s;
        logic [1:0] col_s;
        logic [1:0] xm_s;
        logic [1:0] xf_s;
        logic txc_prev;
        logic rxc_prev;
        logic [7:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_bit;
        logic tx_en;
        logic [7:0] rx_sh;
        logic [2:0] rx_cnt;
        logic rx_push;
        logic [7:0] rx_byte;
        logic overrun;
        logic [3:0] col_cnt;
        logic col;
        logic copy;
        logic recog;
        lmi_pkg::lmi_mode_t md;
    } lmi_st_t;
    lmi_st_t s_q;
    lmi_st_t s_d;
    logic fifo_in_ready;
    logic txc_rise;
    logic txc_fall;
    logic rxc_rise;
    logic mod_in_place;
    assign txc_rise = s_q.txc_s[1] && !s_q.txc_prev;
    assign txc_fall = !s_q.txc_s[1] && s_q.txc_prev;
    assign rxc_rise = s_q.rxc_s[1] && !s_q.rxc_prev;
    assign mod_in_place = !test_in_a && !test_in_b;
    // ---------------------------------------------------------------
    // receive fifo
    // ---------------------------------------------------------------
    lmi_fifo #(
        .WIDTH(lmi_pkg::FIFO_W),
        .DEPTH(lmi_pkg::FIFO_D)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_valid(s_q.rx_push),
        .in_ready(fifo_in_ready),
        .in_data(s_q.rx_byte),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );
    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.txc_s = {s_q.txc_s[0], ring_ref_or_tx_clock};
        s_d.rxc_s = {s_q.rxc_s[0], recovered_or_rx_clock};
        s_d.rxd_s = {s_q.rxd_s[0], rx_serial_in};
        s_d.crs_s = {s_q.crs_s[0], ring_ready_or_carrier};
        s_d.col_s = {s_q.col_s[0], wire_fault_or_collision};
        s_d.xm_s = {s_q.xm_s[0], ext_match};
        s_d.xf_s = {s_q.xf_s[0], ext_fail_to_match};
        s_d.txc_prev = s_q.txc_s[1];
        s_d.rxc_prev = s_q.rxc_s[1];
        s_d.rx_push = 1'b0;
        // mode strap follows the selects; they only move in reset
        if ({net_select_2, net_select_1} == lmi_pkg::NET_CSMA) begin
            s_d.md = lmi_pkg::LMI_MODE_CSMA;
        end else if ({net_select_2, net_select_1} == lmi_pkg::NET_RING) begin
            s_d.md = lmi_pkg::LMI_MODE_RING;
        end else begin
            s_d.md = lmi_pkg::LMI_MODE_OFF;
        end
        // transmit: new bit on the falling txc, held across the rising edge
        if (s_q.md == lmi_pkg::LMI_MODE_CSMA && txc_fall) begin
            if (s_q.tx_cnt != 4'h0) begin
                s_d.tx_bit = s_q.tx_sh[0];
                s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                s_d.tx_cnt = s_q.tx_cnt - 4'h1;
                s_d.tx_en = 1'b1;
            end else begin
                s_d.tx_bit = 1'b0;
                s_d.tx_en = 1'b0;
            end
            if ((s_q.tx_cnt == 4'h0 || s_q.tx_cnt == 4'h1) && tx_valid) begin
                s_d.tx_sh = tx_data;
                s_d.tx_cnt = 4'h8;
                if (s_q.tx_cnt == 4'h0) begin
                    s_d.tx_bit = tx_data[0];
                    s_d.tx_sh = {1'b0, tx_data[7:1]};
                    s_d.tx_cnt = 4'h7;
                    s_d.tx_en = 1'b1;
                end
            end
        end
        // receive: sample on rxc rise while carrier or ready is active
        if (rxc_rise) begin
            if ((s_q.md == lmi_pkg::LMI_MODE_CSMA && s_q.crs_s[1]) ||
                (s_q.md == lmi_pkg::LMI_MODE_RING && !s_q.crs_s[1])) begin
                s_d.rx_sh = {s_q.rxd_s[1], s_q.rx_sh[7:1]};
                s_d.rx_cnt = s_q.rx_cnt + 3'h1;
                if (s_q.rx_cnt == 3'h7) begin
                    s_d.rx_byte = {s_q.rxd_s[1], s_q.rx_sh[7:1]};
                    s_d.rx_push = 1'b1;
                end
            end
        end
        if (s_q.md == lmi_pkg::LMI_MODE_CSMA && !s_q.crs_s[1]) begin
            s_d.rx_cnt = 3'h0;
        end
        if (s_q.md == lmi_pkg::LMI_MODE_RING && s_q.crs_s[1]) begin
            s_d.rx_cnt = 3'h0;
        end
        if (s_q.rx_push && !fifo_in_ready) begin
            s_d.overrun = 1'b1;
        end
        // collision qualified by two transmit clock periods
        if (s_q.md == lmi_pkg::LMI_MODE_CSMA && s_q.col_s[1]) begin
            if (s_q.col_cnt != lmi_pkg::COLL_MIN_CNT) begin
                s_d.col_cnt = s_q.col_cnt + 4'h1;
            end
        end else begin
            s_d.col_cnt = 4'h0;
        end
        s_d.col = s_q.col_cnt == lmi_pkg::COLL_MIN_CNT;
        // external address checker
        if (frame_end) begin
            s_d.copy = 1'b0;
            s_d.recog = 1'b0;
        end
        if (internal_match) begin
            s_d.copy = 1'b1;
            s_d.recog = 1'b1;
        end else if (!copy_all_frames_mode && s_q.xm_s[1] && !s_q.xf_s[1]) begin
            s_d.copy = 1'b1;
            s_d.recog = 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    always_comb begin
        pins_oe = !mod_in_place;
        ring_diff_drive = 1'b1;
        ring_diff_drive_n = 1'b0;
        acq_ctl_or_tx_serial = 1'b0;
        insert_or_loopback_ctl = 1'b0;
        wrap_or_tx_enable = 1'b0;
        unique case (s_q.md)
            lmi_pkg::LMI_MODE_CSMA: begin
                ring_diff_drive = 1'b1;
                ring_diff_drive_n = 1'b0;
                acq_ctl_or_tx_serial = s_q.tx_bit;
                wrap_or_tx_enable = s_q.tx_en;
                insert_or_loopback_ctl = loopback_req;
            end
            lmi_pkg::LMI_MODE_RING: begin
                ring_diff_drive = ring_tx_bit;
                ring_diff_drive_n = !ring_tx_bit;
                acq_ctl_or_tx_serial = wide_acq_req;
                insert_or_loopback_ctl = insert_req;
                wrap_or_tx_enable = !loopback_req;
            end
            default: begin
            end
        endcase
    end
    assign tx_ready = s_q.md == lmi_pkg::LMI_MODE_CSMA && txc_fall &&
        (s_q.tx_cnt == 4'h0 || s_q.tx_cnt == 4'h1);
    assign rx_overrun = s_q.overrun;
    assign carrier_active = s_q.md == lmi_pkg::LMI_MODE_CSMA && s_q.crs_s[1];
    assign collision_seen = s_q.col;
    assign wire_fault = s_q.md == lmi_pkg::LMI_MODE_RING && !s_q.col_s[1];
    assign copy_frame = s_q.copy;
    assign recognized_copied_bits = s_q.recog;
    assign mode = s_q.md;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    csma_drive_pair_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.md == lmi_pkg::LMI_MODE_CSMA |-> ring_diff_drive && !ring_diff_drive_n)
        else $error("drive pair not at reset levels in csma mode");
    tx_on_fall_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $changed(acq_ctl_or_tx_serial) && $past(s_q.md) == lmi_pkg::LMI_MODE_CSMA
        && s_q.md == lmi_pkg::LMI_MODE_CSMA |-> $past(txc_fall))
        else $error("serial data changed away from transmit clock fall");
    tx_enable_data_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.md == lmi_pkg::LMI_MODE_CSMA && !wrap_or_tx_enable |-> !acq_ctl_or_tx_serial)
        else $error("serial data without transmit enable");
    mode_select_a: assert property (@(posedge core_clk) disable iff (!resetn)
        {net_select_2, net_select_1} == lmi_pkg::NET_RING |=> s_q.md == lmi_pkg::LMI_MODE_RING)
        else $error("ring mode not taken");
    ring_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.md == lmi_pkg::LMI_MODE_RING |-> wrap_or_tx_enable == !loopback_req)
        else $error("wrap polarity wrong");
    collision_qual_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(collision_seen) |-> $past(s_q.col_s[1], 2) && $past(s_q.col_s[1], 6))
        else $error("collision accepted too early");
    ext_fail_block_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !internal_match && s_q.xf_s[1] && !s_q.copy && !frame_end |=> !s_q.copy)
        else $error("frame copied despite external fail");
    caf_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
        copy_all_frames_mode && !internal_match && !s_q.recog |=> !s_q.recog)
        else $error("external match used in copy-all mode");
    float_test_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !test_in_a && !test_in_b |-> !pins_oe)
        else $error("outputs driven in module-in-place mode");
endmodule

// >>> lmi_phy_model.sv
// front-end transceiver model driving the media pins
`timescale 1ns/1ps
module lmi_phy_model #(
    parameter int LINK_NS = 320
) (
    output logic tx_clk,
    output logic rx_clk,
    output logic rx_dat,
    output logic carrier,
    output logic coll,
    input wire logic tx_ser,
    input wire logic tx_en,
    output logic [7:0] tx_byte,
    output logic tx_tgl
);
    int nbits;
    initial begin
        {rx_clk, rx_dat, carrier, coll} = '0;
        tx_clk = 1'b1;
        forever #(LINK_NS / 2) tx_clk = ~tx_clk;
    end
    // bit launched at one fall is taken at the next
    initial begin
        {tx_byte, tx_tgl} = '0;
        nbits = 0;
        forever begin
            @(negedge tx_clk);
            if (tx_en === 1'b1) begin
                tx_byte = {tx_ser, tx_byte[7:1]};
                nbits++;
                if (nbits == 8) begin
                    nbits = 0;
                    tx_tgl = ~tx_tgl;
                end
            end else begin
                nbits = 0;
            end
        end
    end
    task automatic frame_start(input logic act);
        carrier = act;
        #(LINK_NS);
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rx_dat = b[i];
            #(LINK_NS / 2) rx_clk = 1'b1;
            #(LINK_NS / 2) rx_clk = 1'b0;
        end
    endtask
    task automatic frame_stop();
        #(LINK_NS / 2) carrier = ~carrier;
        rx_dat = ~rx_dat;
    endtask
    task automatic set_line(input logic v, input int ns);
        coll = v;
        #(ns);
    endtask
endmodule

// >>> lmi_pkg.sv
// package of constants and types for the lan media interface mux
package lmi_pkg;
    // ---------------------------------------------------------------
    // network select codes {net_select_2, net_select_1}
    // ---------------------------------------------------------------
    localparam logic [1:0] NET_CSMA = 2'h2;
    localparam logic [1:0] NET_RING = 2'h3;
    // ---------------------------------------------------------------
    // timing counts
    // ---------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 25;
    localparam int COLL_MIN_TXC = 2;
    localparam int TXC_NS = 100;
    localparam int CORE_NS = 1000 / CORE_CLK_MHZ;
    localparam int COLL_MIN_CYC = (COLL_MIN_TXC * TXC_NS + CORE_NS - 1) / CORE_NS;
    localparam logic [3:0] COLL_MIN_CNT = 4'(COLL_MIN_CYC);
    // ---------------------------------------------------------------
    // fifo shape
    // ---------------------------------------------------------------
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;
    typedef enum logic [1:0] {
        LMI_MODE_OFF,
        LMI_MODE_CSMA,
        LMI_MODE_RING
    } lmi_mode_t;
endpackage

// >>> tb_lan_media_interface_mux.sv
// self-checking bench for the media pin multiplexer
`timescale 1ns/1ps
`define lmi_chk(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, g, e); \
    end \
end
module tb_lan_media_interface_mux;
    logic core_clk, resetn, net_select_0, net_select_1, net_select_2, test_in_a, test_in_b, test_in_c;
    logic ring_ref_or_tx_clock, recovered_or_rx_clock, rx_serial_in, ring_ready_or_carrier;
    logic wire_fault_or_collision, ext_match, ext_fail_to_match, ring_diff_drive, ring_diff_drive_n;
    logic acq_ctl_or_tx_serial, insert_or_loopback_ctl, wrap_or_tx_enable, pins_oe, tx_valid, tx_ready;
    logic loopback_req, wide_acq_req, insert_req, ring_tx_bit, copy_all_frames_mode, internal_match;
    logic frame_end, rx_valid, rx_ready, rx_overrun, carrier_active, collision_seen, wire_fault;
    logic copy_frame, recognized_copied_bits, phy_tgl;
    logic [7:0] tx_data, rx_data, phy_byte, exp_rb, exp_tb;
    logic [1:0] mode;
    logic [31:0] rnd = 32'h53EE;
    logic [7:0] exp_rx [$];
    logic [7:0] exp_tx [$];
    logic [4:0] mt [4] = '{5'h11, 5'h18, 5'h14, 5'h0B};
    int num_errors = 0, num_checks = 0, cycles = 0;

    lmi_media_mux uut (
        .core_clk(core_clk), .resetn(resetn), .net_select_0(net_select_0), .net_select_1(net_select_1),
        .net_select_2(net_select_2), .test_in_a(test_in_a), .test_in_b(test_in_b), .test_in_c(test_in_c),
        .ring_ref_or_tx_clock(ring_ref_or_tx_clock), .recovered_or_rx_clock(recovered_or_rx_clock),
        .rx_serial_in(rx_serial_in), .ring_ready_or_carrier(ring_ready_or_carrier),
        .wire_fault_or_collision(wire_fault_or_collision), .ext_match(ext_match),
        .ext_fail_to_match(ext_fail_to_match), .ring_diff_drive(ring_diff_drive),
        .ring_diff_drive_n(ring_diff_drive_n), .acq_ctl_or_tx_serial(acq_ctl_or_tx_serial),
        .insert_or_loopback_ctl(insert_or_loopback_ctl), .wrap_or_tx_enable(wrap_or_tx_enable),
        .pins_oe(pins_oe), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .loopback_req(loopback_req), .wide_acq_req(wide_acq_req), .insert_req(insert_req),
        .ring_tx_bit(ring_tx_bit), .copy_all_frames_mode(copy_all_frames_mode),
        .internal_match(internal_match), .frame_end(frame_end), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_overrun(rx_overrun), .carrier_active(carrier_active),
        .collision_seen(collision_seen), .wire_fault(wire_fault), .copy_frame(copy_frame),
        .recognized_copied_bits(recognized_copied_bits), .mode(mode)
    );
    lmi_phy_model #(.LINK_NS(320)) phy (
        .tx_clk(ring_ref_or_tx_clock),
        .rx_clk(recovered_or_rx_clock),
        .rx_dat(rx_serial_in),
        .carrier(ring_ready_or_carrier),
        .coll(wire_fault_or_collision),
        .tx_ser(acq_ctl_or_tx_serial),
        .tx_en(wrap_or_tx_enable),
        .tx_byte(phy_byte),
        .tx_tgl(phy_tgl)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] sel);
        resetn = 1'b0;
        rnd = lfsr(rnd);
        {net_select_2, net_select_1, net_select_0} = {sel, rnd[0]};
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic send_tx();
        rnd = lfsr(rnd);
        tx_valid = 1'b1;
        tx_data = rnd[7:0];
        exp_tx.push_back(rnd[7:0]);
        while (tx_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic rx_byte(input logic keep);
        rnd = lfsr(rnd);
        if (keep) exp_rx.push_back(rnd[7:0]);
        phy.send_byte(rnd[7:0]);
    endtask
    task automatic check_pins(input logic ring);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            {test_in_c, ring_tx_bit, wide_acq_req, insert_req, loopback_req} = rnd[4:0];
            @(negedge core_clk);
            if (ring) begin
                `lmi_chk({ring_diff_drive, ring_diff_drive_n}, {ring_tx_bit, !ring_tx_bit})
                `lmi_chk(acq_ctl_or_tx_serial, wide_acq_req)
                `lmi_chk(insert_or_loopback_ctl, insert_req)
                `lmi_chk(wrap_or_tx_enable, !loopback_req)
            end else begin
                `lmi_chk({ring_diff_drive, ring_diff_drive_n}, 2'h2)
                `lmi_chk(insert_or_loopback_ctl, loopback_req)
            end
        end
    endtask

    // ----------
    // watchers
    // ----------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            test_done();
        end
    end
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            exp_rb = (exp_rx.size() > 0) ? exp_rx.pop_front() : 8'hXX;
            `lmi_chk(rx_data, exp_rb)
        end
    end
    always @(phy_tgl) begin
        if (mode === lmi_pkg::LMI_MODE_CSMA) begin
            exp_tb = (exp_tx.size() > 0) ? exp_tx.pop_front() : 8'hXX;
            `lmi_chk(phy_byte, exp_tb)
        end
    end

    // ----------
    // stimulus
    // ----------
    initial begin
        {net_select_0, tx_valid, tx_data, loopback_req, wide_acq_req, insert_req, ring_tx_bit} = '0;
        {copy_all_frames_mode, internal_match, frame_end, ext_match, ext_fail_to_match} = '0;
        {test_in_a, test_in_b, test_in_c, rx_ready} = 4'hF;
        for (int i = 0; i < 4; i++) begin
            do_reset(2'(i));
            `lmi_chk(mode, (i == 2) ? lmi_pkg::LMI_MODE_CSMA : (i == 3) ? lmi_pkg::LMI_MODE_RING : 2'h0)
        end
        check_pins(1'b1);
        phy.set_line(1'b1, 400);
        `lmi_chk(wire_fault, 1'b0)
        phy.set_line(1'b0, 400);
        `lmi_chk(wire_fault, 1'b1)
        phy.frame_start(1'b1);
        rx_byte(1'b0);
        phy.frame_start(1'b0);
        rx_byte(1'b1);
        phy.frame_stop();
        repeat (10) @(negedge core_clk);
        phy.frame_start(1'b0);
        do_reset(lmi_pkg::NET_CSMA);
        check_pins(1'b0);
        loopback_req = 1'b0;
        {test_in_a, test_in_b} = 2'h0;
        repeat (2) @(negedge core_clk);
        `lmi_chk(pins_oe, 1'b0)
        {test_in_a, test_in_b} = 2'h3;
        repeat (2) @(negedge core_clk);
        `lmi_chk(pins_oe, 1'b1)
        repeat (3) send_tx();
        tx_valid = 1'b0;
        repeat (100) @(negedge core_clk);
        `lmi_chk({wrap_or_tx_enable, exp_tx.size() == 0}, 2'h1)
        phy.frame_start(1'b1);
        `lmi_chk(carrier_active, 1'b1)
        repeat (3) rx_byte(1'b1);
        phy.frame_stop();
        repeat (8) @(negedge core_clk);
        `lmi_chk(carrier_active, 1'b0)
        rx_ready = 1'b0;
        phy.frame_start(1'b1);
        for (int i = 0; i < 10; i++) rx_byte(i < 8);
        phy.frame_stop();
        repeat (4) @(negedge core_clk);
        `lmi_chk(rx_overrun, 1'b1)
        rx_ready = 1'b1;
        repeat (20) @(negedge core_clk);
        `lmi_chk(exp_rx.size() == 0, 1'b1)
        phy.set_line(1'b1, 120);
        phy.set_line(1'b0, 400);
        `lmi_chk(collision_seen, 1'b0)
        phy.set_line(1'b1, 640);
        `lmi_chk(collision_seen, 1'b1)
        phy.set_line(1'b0, 400);
        foreach (mt[i]) begin
            {ext_match, ext_fail_to_match, copy_all_frames_mode, internal_match} = mt[i][4:1];
            repeat (6) @(negedge core_clk);
            `lmi_chk({copy_frame, recognized_copied_bits}, {2{mt[i][0]}})
            {ext_match, ext_fail_to_match, copy_all_frames_mode, internal_match} = 4'h0;
            repeat (4) @(negedge core_clk);
            frame_end = 1'b1;
            @(negedge core_clk);
            frame_end = 1'b0;
            repeat (2) @(negedge core_clk);
            `lmi_chk(copy_frame, 1'b0)
        end
        test_done();
    end
endmodule
